// *** core/debug_trace_pkg.sv ***
/*
  Shared constants and carrier types for the debug trace and serial port.
  Assumes a single processor clock domain plus the serial link clock.
*/
package debug_trace_pkg;

  // Serial link framing.
  localparam int            WORD_BITS      = 16;
  localparam logic [3:0]    BIT_CNT_LAST   = 4'hF;
  localparam logic [3:0]    BIT_CNT_FIRST  = 4'h0;
  localparam logic [15:0]   RESP_RESET     = 16'h0000;

  // Status codes that may open the trace during reset exception processing.
  localparam logic [3:0]    START_CODE_C   = 4'hC;
  localparam logic [3:0]    START_CODE_D   = 4'hD;
  localparam logic [3:0]    START_CODE_F   = 4'hF;
  localparam logic [3:0]    STATUS_RESET   = 4'h0;
  localparam logic [3:0]    DBG_DATA_RESET = 4'h0;

  // Breakpoint status nibble shown on the debug data bus.
  localparam int            STAT_FIRE_BIT  = 3;
  localparam int            STAT_ARMED_BIT = 2;
  localparam int            STAT_MODE_BIT  = 1;
  localparam int            NUM_PC_BKPT    = 4;

  // Core execution trace as seen by the port.
  typedef struct packed {
    logic [3:0] status;
    logic       capture_valid;
    logic [3:0] capture_nibble;
  } core_trace_t;

  // Bus values watched by the comparators.
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic [31:0] addr;
    logic [31:0] data;
  } bus_watch_t;

  // Breakpoint configuration.
  typedef struct packed {
    logic                   two_level;
    logic [NUM_PC_BKPT-1:0] pc_en;
    logic [3:0][31:0]       pc_value;
    logic                   addr_en;
    logic [31:0]            addr_value;
    logic                   data_en;
    logic [31:0]            data_value;
  } bkpt_cfg_t;

endpackage : debug_trace_pkg

// *** core/debug_serial_link.sv ***
/*
  Link-side shifter of the debug serial port, clocked by the serial clock.
  Assumes the response word is held stable by the processor side while a
  frame is running, and that the link reset comes from rst via three flops.
*/
`timescale 1ns/1ps
module debug_serial_link
  import debug_trace_pkg::*;
(
  input  wire logic                 link_clk,
  input  wire logic                 rst,
  input  wire logic                 serial_in,
  output logic                      serial_out,
  input  wire logic [WORD_BITS-1:0] resp_word,
  output logic [WORD_BITS-1:0]      rx_word,
  output logic                      rx_toggle
);

  logic                 rst_s1_reg;
  logic                 rst_s2_reg;
  logic                 rst_s3_reg;
  logic                 link_rst_reg;
  logic                 link_rst_next;
  logic [3:0]           bit_cnt_reg;
  logic [WORD_BITS-1:0] rx_shift_reg;
  logic [WORD_BITS-1:0] rx_shift_next;
  logic [WORD_BITS-1:0] tx_shift_reg;
  logic [WORD_BITS-1:0] tx_shift_next;
  logic                 serial_out_reg;
  logic [WORD_BITS-1:0] rx_word_reg;
  logic                 rx_toggle_reg;
  wire                  frame_last = (bit_cnt_reg == BIT_CNT_LAST);
  wire                  frame_first = (bit_cnt_reg == BIT_CNT_FIRST);

  // Reset is carried into the link domain by three flops and counts once the
  // second and third agree. The link clock may stand still, so reset takes
  // effect only on later serial edges, four of them each way.
  always_ff @(posedge link_clk) begin
    rst_s1_reg   <= rst;
    rst_s2_reg   <= rst_s1_reg;
    rst_s3_reg   <= rst_s2_reg;
    link_rst_reg <= link_rst_next;
  end

  // A disagreement between the last two stages keeps the previous level.
  assign link_rst_next = (rst_s2_reg == rst_s3_reg) ? rst_s3_reg : link_rst_reg;

  // Input bits are taken on the rising serial edge, once the clock is high.
  assign rx_shift_next = {rx_shift_reg[WORD_BITS-2:0], serial_in};
  // The response word is loaded at the first bit of each frame.
  assign tx_shift_next = frame_first ? resp_word : tx_shift_reg;

  // Shift both directions; the output flop changes just after the edge.
  always_ff @(posedge link_clk) begin
    if (link_rst_reg) begin
      bit_cnt_reg    <= BIT_CNT_FIRST;
      rx_shift_reg   <= RESP_RESET;
      tx_shift_reg   <= RESP_RESET;
      serial_out_reg <= 1'b0;
      rx_word_reg    <= RESP_RESET;
      rx_toggle_reg  <= 1'b0;
    end else begin
      bit_cnt_reg    <= bit_cnt_reg + 4'h1;
      rx_shift_reg   <= rx_shift_next;
      tx_shift_reg   <= {tx_shift_next[WORD_BITS-2:0], 1'b0};
      serial_out_reg <= tx_shift_next[WORD_BITS-1];
      if (frame_last) begin
        rx_word_reg   <= rx_shift_next;
        rx_toggle_reg <= ~rx_toggle_reg;
      end
    end
  end

  assign serial_out = serial_out_reg;
  assign rx_word    = rx_word_reg;
  assign rx_toggle  = rx_toggle_reg;

  a_word_done: assert property (@(posedge link_clk) disable iff (link_rst_reg)
    frame_last |=> (rx_toggle_reg != $past(rx_toggle_reg)) &&
                   (rx_word_reg == $past(rx_shift_next)))
    else $error("Received word not delivered at frame end.");

  a_out_registered: assert property (@(posedge link_clk) disable iff (link_rst_reg)
    frame_first && !link_rst_reg |=> serial_out_reg == $past(resp_word[WORD_BITS-1]))
    else $error("Serial output did not start with response MSB.");

endmodule : debug_serial_link

// *** core/debug_trace_port.sv ***
/*
  Debug trace and serial port: status and debug data trace outputs, trace
  clock, breakpoint comparators and the processor side of the serial link.
  Assumes core status, watched bus values and breakpoint settings arrive on
  sys_clk, and that the serial clock comes from the external probe.
*/
// Notes on behaviour
// - Serial input is taken unsynchronised, straight into the shifter, on each rising serial clock edge.
// - Serial output comes from a register that changes just after the rising edge.
// - Captured data or breakpoint status appears on the four-bit debug data bus.
// - Trace clock is a gated, inverted processor clock, rising mid data window.
// - Disable bit set freezes trace clock, status and debug data; triggers still work.
// - Clearing the disable bit makes trace clock and outputs toggle again.
// - Trace clock stays idle until status 0xC, 0xD or 0xF first appears.
// - Status code follows the core on the processor clock, not bus transfers.
// - All-ones indicator is the AND of the four status bits.
// - Six breakpoints: four on PC, one address, one data; one or two levels.
`timescale 1ns/1ps
module debug_trace_port
  import debug_trace_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire core_trace_t          core_trace,
  input  wire bus_watch_t           bus_watch,
  input  wire bkpt_cfg_t            bkpt_cfg,
  input  wire logic                 trace_clock_disable,
  input  wire logic                 debug_serial_clock,
  input  wire logic                 debug_serial_in,
  output logic                      debug_serial_out,
  output logic [WORD_BITS-1:0]      debug_cmd_data,
  output logic                      debug_cmd_valid,
  input  wire logic [WORD_BITS-1:0] debug_resp_data,
  input  wire logic                 debug_resp_valid,
  output logic [3:0]                processor_status_code,
  output logic [3:0]                debug_data_out,
  output logic                      status_all_ones,
  output logic                      trace_status_clock,
  output logic                      breakpoint_hit
);

  // Match decode shared by all six comparators.
  function automatic logic bkpt_match(input logic en, input logic [31:0] val,
                                      input logic [31:0] ref_val);
    bkpt_match = en && (val == ref_val);
  endfunction : bkpt_match

  // Start codes that open the trace clock after reset.
  function automatic logic is_start_code(input logic [3:0] code);
    is_start_code = (code == START_CODE_C) || (code == START_CODE_D) ||
                    (code == START_CODE_F);
  endfunction : is_start_code

  logic                   quiet_reg;
  logic                   started_reg;
  logic                   clk_en_reg;
  logic [3:0]             status_reg;
  logic [3:0]             dbg_data_reg;
  logic                   all_ones_reg;
  logic                   armed_reg;
  logic                   fire_reg;
  logic [NUM_PC_BKPT-1:0] pc_hit;
  logic [3:0]             status_next;
  logic [3:0]             dbg_data_next;
  logic [3:0]             bkpt_status;
  logic                   addr_hit;
  logic                   data_hit;
  logic                   level1_hit;
  logic                   level2_hit;
  logic                   fire_next;
  logic                   armed_next;
  logic [WORD_BITS-1:0]   resp_hold_reg;
  logic [WORD_BITS-1:0]   cmd_data_reg;
  logic                   cmd_valid_reg;
  logic [WORD_BITS-1:0]   link_rx_word;
  logic                   link_rx_toggle;
  logic                   tgl_s1_reg;
  logic                   tgl_s2_reg;
  logic                   tgl_s3_reg;
  logic                   tgl_seen_reg;
  wire                    word_arrived = (tgl_s2_reg == tgl_s3_reg) &&
                                         (tgl_s3_reg != tgl_seen_reg);
  wire                    tgl_seen_next = word_arrived ? tgl_s3_reg : tgl_seen_reg;

  // Four program counter comparators.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PC_BKPT; gi++) begin : g_pc_cmp
      assign pc_hit[gi] = bus_watch.valid &&
                          bkpt_match(bkpt_cfg.pc_en[gi], bus_watch.pc,
                                     bkpt_cfg.pc_value[gi]);
    end
  endgenerate

  // Address and data comparators, then the one- or two-level trigger. In two
  // levels any PC hit arms and an address or data hit then fires.
  assign addr_hit   = bus_watch.valid &&
                      bkpt_match(bkpt_cfg.addr_en, bus_watch.addr, bkpt_cfg.addr_value);
  assign data_hit   = bus_watch.valid &&
                      bkpt_match(bkpt_cfg.data_en, bus_watch.data, bkpt_cfg.data_value);
  assign level1_hit = |pc_hit;
  assign level2_hit = addr_hit | data_hit;
  assign fire_next  = bkpt_cfg.two_level ? (armed_reg & level2_hit)
                                         : (level1_hit | level2_hit);
  assign armed_next = bkpt_cfg.two_level & ~fire_next & (armed_reg | level1_hit);

  // Trace values; they hold while trace is quiet, triggers run regardless.
  assign bkpt_status = {fire_reg, armed_reg, bkpt_cfg.two_level, 1'b0};
  assign dbg_data_next = quiet_reg ? dbg_data_reg :
                       core_trace.capture_valid ? core_trace.capture_nibble
                                                : bkpt_status;
  assign status_next = quiet_reg ? status_reg : core_trace.status;

  // Trace control and output flops.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      quiet_reg    <= 1'b0;
      started_reg  <= 1'b0;
      clk_en_reg   <= 1'b0;
      status_reg   <= STATUS_RESET;
      dbg_data_reg <= DBG_DATA_RESET;
      all_ones_reg <= 1'b0;
      armed_reg    <= 1'b0;
      fire_reg     <= 1'b0;
    end else begin
      quiet_reg    <= trace_clock_disable;
      started_reg  <= started_reg | is_start_code(core_trace.status);
      clk_en_reg   <= started_reg & ~quiet_reg;
      status_reg   <= status_next;
      dbg_data_reg <= dbg_data_next;
      all_ones_reg <= &status_next;
      armed_reg    <= armed_next;
      fire_reg     <= fire_next;
    end
  end

  // The trace clock rises on the falling processor edge, mid-way through the
  // window in which registered trace data is stable. The enable changes only
  // while sys_clk is high, so the gated clock cannot glitch.
  assign trace_status_clock    = clk_en_reg & ~sys_clk;
  assign processor_status_code = status_reg;
  assign debug_data_out        = dbg_data_reg;
  assign status_all_ones       = all_ones_reg;
  assign breakpoint_hit        = fire_reg;

  // Word toggle from the link domain: three flops, a change counts once the
  // second and third agree. The word itself is stable for a whole frame.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tgl_s1_reg   <= 1'b0;
      tgl_s2_reg   <= 1'b0;
      tgl_s3_reg   <= 1'b0;
      tgl_seen_reg <= 1'b0;
    end else begin
      tgl_s1_reg   <= link_rx_toggle;
      tgl_s2_reg   <= tgl_s1_reg;
      tgl_s3_reg   <= tgl_s2_reg;
      tgl_seen_reg <= tgl_seen_next;
    end
  end

  // Command capture and response holding on the processor side.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_data_reg  <= RESP_RESET;
      cmd_valid_reg <= 1'b0;
      resp_hold_reg <= RESP_RESET;
    end else begin
      cmd_valid_reg <= word_arrived;
      if (word_arrived) begin
        cmd_data_reg <= link_rx_word;
      end
      if (debug_resp_valid) begin
        resp_hold_reg <= debug_resp_data;
      end
    end
  end

  assign debug_cmd_data  = cmd_data_reg;
  assign debug_cmd_valid = cmd_valid_reg;

  debug_serial_link u_link (
    .link_clk   (debug_serial_clock),
    .rst        (rst),
    .serial_in  (debug_serial_in),
    .serial_out (debug_serial_out),
    .resp_word  (resp_hold_reg),
    .rx_word    (link_rx_word),
    .rx_toggle  (link_rx_toggle)
  );

  a_status_follows: assert property (@(posedge sys_clk) disable iff (rst)
    !quiet_reg |=> status_reg == $past(core_trace.status))
    else $error("Status code did not follow the core.");

  a_quiet_hold: assert property (@(posedge sys_clk) disable iff (rst)
    quiet_reg |=> $stable(status_reg) && $stable(dbg_data_reg) && !clk_en_reg)
    else $error("Trace outputs moved while disabled.");

  a_trigger_alive: assert property (@(posedge sys_clk) disable iff (rst)
    quiet_reg && !bkpt_cfg.two_level && level1_hit |=> fire_reg)
    else $error("Breakpoint lost while trace disabled.");

  a_trace_resume: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(quiet_reg) && started_reg |=> clk_en_reg)
    else $error("Trace clock did not resume.");

  a_start_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !started_reg |=> !clk_en_reg)
    else $error("Trace clock ran before a start code.");

  a_start_code: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(started_reg) |-> is_start_code($past(core_trace.status)))
    else $error("Trace started on a wrong status code.");

  a_all_ones: assert property (@(posedge sys_clk) disable iff (rst)
    status_all_ones == (&processor_status_code))
    else $error("All-ones indicator disagrees with status.");

  a_data_show: assert property (@(posedge sys_clk) disable iff (rst)
    !quiet_reg && core_trace.capture_valid |=> dbg_data_reg == $past(core_trace.capture_nibble))
    else $error("Captured data not shown on debug data bus.");

  a_two_level: assert property (@(posedge sys_clk) disable iff (rst)
    bkpt_cfg.two_level && !armed_reg |=> !fire_reg)
    else $error("Two-level trigger fired without arming.");

  a_reset_quiet: assert property (@(posedge sys_clk)
    rst |=> !quiet_reg && !clk_en_reg)
    else $error("Disable bit not cleared by reset.");

endmodule : debug_trace_port

// *** tb/debug_probe_model.sv ***
/*
  Behavioural probe on the far side of the debug port: it makes the serial clock
  and data and counts trace clock edges. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module debug_probe_model (
  output logic      debug_serial_clock,
  output logic      debug_serial_in,
  input  wire logic debug_serial_out,
  input  wire logic trace_status_clock
);
  int          tsc_edges;
  logic [15:0] rx_word;

  // Trace is taken on the rising trace clock. The bench only looks at
  // differences of this count, so no phase is assumed across a pause.
  always @(posedge trace_status_clock) tsc_edges++;

  initial begin
    debug_serial_clock = 1'b0;
    debug_serial_in    = 1'b0;
    tsc_edges          = 0;
    rx_word            = 16'h0000;
  end

  // Bare clock pulses, used only while reset holds the link.
  task automatic pulses(input int n);
    repeat (n) begin
      #40 debug_serial_clock = 1'b1;
      #40 debug_serial_clock = 1'b0;
    end
  endtask : pulses

  // One frame, MSB first. Data is held across each rising edge and the
  // output is read at the falling edge, after it settled.
  task automatic frame(input logic [15:0] w);
    #17;
    for (int i = 15; i >= 0; i--) begin
      debug_serial_in = w[i];
      #40 debug_serial_clock = 1'b1;
      #40 debug_serial_clock = 1'b0;
      rx_word = {rx_word[14:0], debug_serial_out};
    end
    debug_serial_in = ~w[0]; // A released line shows no stale bit.
  endtask : frame
endmodule : debug_probe_model

// *** tb/debug_trace_port_tb.sv ***
/*
  Self-checking bench for the debug trace port, with the probe model.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/1ps
module debug_trace_port_tb;
  import debug_trace_pkg::*;
  typedef struct packed {int cyc; logic [3:0] st; logic [3:0] dd;} trace_exp_t;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  core_trace_t          core_trace;
  bus_watch_t           bus_watch;
  bkpt_cfg_t            bkpt_cfg;
  logic                 trace_clock_disable, debug_serial_clock, debug_serial_in;
  logic                 debug_serial_out, debug_cmd_valid, debug_resp_valid;
  logic [WORD_BITS-1:0] debug_cmd_data, debug_resp_data, w, r;
  logic [3:0]           processor_status_code, debug_data_out, snap_st, snap_dd, exp_dd;
  logic                 cap_on = 1'b1;
  logic                 status_all_ones, trace_status_clock, breakpoint_hit;
  int                   seed = 3907, cyc = 0, n_hit = 0, n_mismatch = 0, n_tests = 0, h, e0;
  trace_exp_t           trace_q[$];
  logic [15:0]          cmd_q[$];
  logic [3:0]           codes[3] = '{START_CODE_C, START_CODE_D, START_CODE_F};

  debug_trace_port i_debug_trace_port (.sys_clk(sys_clk), .rst(rst), .core_trace(core_trace),
    .bus_watch(bus_watch), .bkpt_cfg(bkpt_cfg), .trace_clock_disable(trace_clock_disable),
    .debug_serial_clock(debug_serial_clock), .debug_serial_in(debug_serial_in),
    .debug_serial_out(debug_serial_out), .debug_cmd_data(debug_cmd_data),
    .debug_cmd_valid(debug_cmd_valid), .debug_resp_data(debug_resp_data),
    .debug_resp_valid(debug_resp_valid), .processor_status_code(processor_status_code),
    .debug_data_out(debug_data_out), .status_all_ones(status_all_ones),
    .trace_status_clock(trace_status_clock), .breakpoint_hit(breakpoint_hit));
  debug_probe_model i_debug_probe_model (.debug_serial_clock(debug_serial_clock),
    .debug_serial_in(debug_serial_in), .debug_serial_out(debug_serial_out),
    .trace_status_clock(trace_status_clock));

  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test;
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // Results are compared at the falling edge, well after they launched.
  always @(negedge sys_clk) begin
    trace_exp_t e;
    if (breakpoint_hit === 1'b1) n_hit++;
    if (trace_q.size() > 0 && trace_q[0].cyc < cyc) begin
      e = trace_q.pop_front();
      check(e.st === processor_status_code && e.dd === debug_data_out, "trace");
      check((&e.st) === status_all_ones, "all ones flag");
    end
    if (debug_cmd_valid === 1'b1) begin
      check(cmd_q.size() > 0 && debug_cmd_data === cmd_q.pop_front(), "command");
    end
  end

  function automatic bus_watch_t any_bw();
    return '{1'b1, 32'($random(seed)), 32'($random(seed)), 32'($random(seed))};
  endfunction : any_bw

  // One core cycle; inputs change 1 ns after the edge, the note goes on the queue when push is set.
  task automatic step(input logic [3:0] st, input bit push, input bus_watch_t bw);
    @(posedge sys_clk);
    #1;
    core_trace = '{status: st, capture_valid: cap_on, capture_nibble: 4'($random(seed))};
    bus_watch = bw;
    if (push) trace_q.push_back('{cyc: cyc, st: st,
                                 dd: cap_on ? core_trace.capture_nibble : exp_dd});
  endtask : step

  // Kind 0..3 hits a program counter comparator, 4 the address, 5 the data one.
  task automatic bp_step(input int kind, input bit push);
    bus_watch_t b;
    b = any_bw();
    if (kind < 4) b.pc = bkpt_cfg.pc_value[kind];
    if (kind == 4) b.addr = bkpt_cfg.addr_value;
    if (kind == 5) b.data = bkpt_cfg.data_value;
    step(4'($random(seed)), push, b);
  endtask : bp_step

  // Three quiet cycles cover the longest hit latency before counting.
  task automatic expect_hits(input int exp, input bit push);
    repeat (3) step(4'($random(seed)), push, any_bw());
    check(n_hit - h == exp, "breakpoint hits");
  endtask : expect_hits

  // The link resets only while its clock runs: its synchroniser needs four
  // serial edges each way, so it gets pulses under reset and four after it,
  // which still fall in link reset and leave the frame counter at zero. The
  // core status is cleared so no stale start code is seen at release.
  task automatic do_reset;
    @(posedge sys_clk);
    #1 rst = 1'b1;
    core_trace = '0;
    fork i_debug_probe_model.pulses(5); join_none
    repeat (5) @(posedge sys_clk);
    #1 rst = 1'b0;
    i_debug_probe_model.pulses(4);
  endtask : do_reset

  initial begin
    core_trace = '0; bus_watch = '0; trace_clock_disable = 1'b0; bkpt_cfg = '0;
    debug_resp_data = 16'h0000; debug_resp_valid = 1'b0;
    bkpt_cfg.pc_en = 4'hF; bkpt_cfg.addr_en = 1'b1; bkpt_cfg.data_en = 1'b1;
    for (int i = 0; i < 4; i++) bkpt_cfg.pc_value[i] = $random(seed);
    bkpt_cfg.addr_value = $random(seed);
    bkpt_cfg.data_value = $random(seed);
    // Other codes leave the trace clock idle; each start code then runs it from two edges on.
    foreach (codes[c]) begin
      do_reset();
      e0 = i_debug_probe_model.tsc_edges;
      for (int i = 0; i < 12; i++) step(4'(i), 1'b1, any_bw());
      check(i_debug_probe_model.tsc_edges == e0, "trace clock idle");
      e0 = i_debug_probe_model.tsc_edges;
      step(codes[c], 1'b1, any_bw());
      repeat (19) step(4'($random(seed)), 1'b1, any_bw());
      check(i_debug_probe_model.tsc_edges - e0 == 17, "trace clock start");
    end
    h = n_hit;
    for (int k = 0; k < 6; k++) bp_step(k, 1'b1);
    expect_hits(6, 1'b1);
    // Disabled trace freezes the outputs, yet a breakpoint still fires.
    trace_clock_disable = 1'b1;
    repeat (2) step(4'($random(seed)), 1'b0, any_bw());
    snap_st = processor_status_code; snap_dd = debug_data_out;
    e0 = i_debug_probe_model.tsc_edges; h = n_hit;
    bp_step(2, 1'b0);
    expect_hits(1, 1'b0);
    check(processor_status_code === snap_st && debug_data_out === snap_dd, "frozen");
    check(i_debug_probe_model.tsc_edges == e0, "trace clock stopped");
    trace_clock_disable = 1'b0;
    e0 = i_debug_probe_model.tsc_edges;
    repeat (10) step(4'($random(seed)), 1'b1, any_bw());
    check(i_debug_probe_model.tsc_edges - e0 == 8, "trace clock resumed");
    // Two levels: an unarmed address hit is ignored, an armed one fires once.
    bkpt_cfg.two_level = 1'b1;
    h = n_hit; bp_step(4, 1'b1); expect_hits(0, 1'b1);
    // With no capture, the armed trigger shows as breakpoint status on the bus.
    exp_dd = 4'h0;
    exp_dd[STAT_ARMED_BIT] = 1'b1;
    exp_dd[STAT_MODE_BIT] = 1'b1;
    h = n_hit;
    bp_step(0, 1'b1);
    cap_on = 1'b0;
    bp_step(4, 1'b1);
    cap_on = 1'b1;
    expect_hits(1, 1'b1);
    h = n_hit; bp_step(3, 1'b1); bp_step(5, 1'b1); expect_hits(1, 1'b1);
    // Serial frames: the response goes in first, then a word crosses each way.
    for (int i = 0; i < 3; i++) begin
      w = 16'($random(seed));
      r = 16'($random(seed));
      @(posedge sys_clk); #1 debug_resp_data = r; debug_resp_valid = 1'b1;
      @(posedge sys_clk); #1 debug_resp_valid = 1'b0;
      repeat (4) @(posedge sys_clk);
      cmd_q.push_back(w);
      i_debug_probe_model.frame(w);
      for (int k = 0; k < 20 && cmd_q.size() > 0; k++) @(posedge sys_clk);
      if (cmd_q.size() > 0) begin
        n_mismatch++;
        break;
      end
      check(i_debug_probe_model.rx_word === r, "response word");
    end
    stop_test();
  end
endmodule : debug_trace_port_tb
